// >>> include/cfgl_map.vh
// register offsets, field positions and reset values of the link configuration loader
// assumes byte offsets within the device's extended configuration space
`ifndef CFGL_MAP_VH
`define CFGL_MAP_VH
`define CFGL_OFS_ID_STATUS 12'h21C
`define CFGL_OFS_MODE 12'h220
`define CFGL_OFS_DATA 12'h228
`define CFGL_ST_CORE_READY 9
`define CFGL_ST_CLOCK_ACTIVE 8
`define CFGL_ST_DONE 7
`define CFGL_ST_HALF_RATE 6
`define CFGL_ST_RUNNING 5
`define CFGL_ST_ENABLED 4
`define CFGL_ST_ERROR 3
`define CFGL_ST_READY 2
`define CFGL_MODE_CLKS_HI 15
`define CFGL_MODE_CLKS_LO 8
`define CFGL_MODE_CLKS_USED_HI 13
`define CFGL_MODE_RELOAD 2
`define CFGL_MODE_CLKSRC 1
`define CFGL_MODE_PROTO 0
`define CFGL_CLKS_RESET 8'h00
`define CFGL_DATA_RESET 32'h00000000
`define CFGL_ZERO_COUNT_CLKS 7'h40
`endif

// >>> logic/cfgl_pulser.v
// emits a burst of clock pulses toward the configuration controller, one per two mclk
// assumes a start pulse arrives only while idle
`timescale 1ns/10ps
module cfgl_pulser (
    mclk,
    sys_rst,
    start,
    count,
    pulse_clk,
    busy
);
    input wire mclk;
    input wire sys_rst;
    input wire start;
    input wire [6:0] count;
    output reg pulse_clk;
    output wire busy;
    reg [6:0] left;
    // busy must not follow start: the parent gates start with busy
    assign busy = (left != 7'h00);
    always @(posedge mclk) begin
        if (sys_rst) begin
            left <= 7'h00;
            pulse_clk <= 1'b0;
        end else if (start && left == 7'h00) begin
            left <= count;
            pulse_clk <= 1'b0;
        end else if (left != 7'h00) begin
            pulse_clk <= ~pulse_clk;
            if (pulse_clk) begin
                left <= left - 7'h01;
            end
        end else begin
            pulse_clk <= 1'b0;
        end
    end
endmodule // cfgl_pulser

// >>> logic/cfgl_regs.v
// register side of configuration over the link: id, status, mode control and data
// assumes cfg_* strobes come from the link core's configuration access logic
`timescale 1ns/10ps
`include "cfgl_map.vh"
module cfgl_regs #(
    parameter [15:0] BOARD_TYPE_ID = 16'h0000
) (
    mclk,
    sys_rst,
    cfg_wr,
    cfg_rd,
    cfg_addr,
    cfg_wdata,
    cfg_be,
    cfg_rdata,
    mem_wr,
    mem_bar_hit,
    mem_wdata,
    mem_be,
    fabric_core_ready,
    fabric_clock_active,
    load_done,
    half_rate_select,
    fabric_running,
    load_enabled,
    load_error,
    load_ready,
    load_data,
    load_clk,
    load_busy,
    protocol_load_mode,
    whole_device_reload,
    core_clock_source,
    core_clock_source_apply,
    route_to_config
);
    input wire mclk;
    input wire sys_rst;
    input wire cfg_wr;
    input wire cfg_rd;
    input wire [11:0] cfg_addr;
    input wire [31:0] cfg_wdata;
    input wire [3:0] cfg_be;
    output reg [31:0] cfg_rdata;
    input wire mem_wr;
    input wire mem_bar_hit;
    input wire [31:0] mem_wdata;
    input wire [3:0] mem_be;
    input wire fabric_core_ready;
    input wire fabric_clock_active;
    input wire load_done;
    input wire half_rate_select;
    input wire fabric_running;
    input wire load_enabled;
    input wire load_error;
    input wire load_ready;
    output reg [31:0] load_data;
    output wire load_clk;
    output wire load_busy;
    output reg protocol_load_mode;
    output reg whole_device_reload;
    output reg core_clock_source;
    output wire core_clock_source_apply;
    output wire route_to_config;

    wire [7:0] st;
    reg [7:0] clocks_per_word;
    wire [15:0] status_word;
    wire [31:0] mode_word;
    wire wr_mode;
    wire cfg_data_wr;
    wire mem_data_wr;
    wire data_wr;
    wire [6:0] pulse_count;
    wire [31:0] wr_word;
    wire [3:0] wr_lanes;
    reg [31:0] next_load_data;
    reg [31:0] next_rdata;

    // each status level crosses into mclk through its own synchroniser
    cfgl_sync u_sync_core_ready (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .din(fabric_core_ready),
        .dout(st[7])
    );

    cfgl_sync u_sync_clock_active (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .din(fabric_clock_active),
        .dout(st[6])
    );

    cfgl_sync u_sync_done (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .din(load_done),
        .dout(st[5])
    );

    cfgl_sync u_sync_half_rate (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .din(half_rate_select),
        .dout(st[4])
    );

    cfgl_sync u_sync_running (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .din(fabric_running),
        .dout(st[3])
    );

    cfgl_sync u_sync_enabled (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .din(load_enabled),
        .dout(st[2])
    );

    cfgl_sync u_sync_error (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .din(load_error),
        .dout(st[1])
    );

    cfgl_sync u_sync_ready (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .din(load_ready),
        .dout(st[0])
    );

    assign status_word = {6'h00,
                          st[7],
                          st[6],
                          st[5],
                          st[4],
                          st[3],
                          st[2],
                          st[1],
                          st[0],
                          2'h0};

    // reserved bits including bit 3 read zero
    assign mode_word = {16'h0000, clocks_per_word, 5'h00, whole_device_reload,
                        core_clock_source, protocol_load_mode};

    assign wr_mode = cfg_wr && (cfg_addr == `CFGL_OFS_MODE);
    assign cfg_data_wr = cfg_wr && (cfg_addr == `CFGL_OFS_DATA);
    assign mem_data_wr = mem_wr && mem_bar_hit && protocol_load_mode;
    assign data_wr = (cfg_data_wr || mem_data_wr) && !load_busy;

    always @(posedge mclk) begin
        if (sys_rst) begin
            clocks_per_word <= `CFGL_CLKS_RESET;
            whole_device_reload <= 1'b0;
            core_clock_source <= 1'b0;
            protocol_load_mode <= 1'b0;
        end else begin
            if (wr_mode && cfg_be[1]) begin
                clocks_per_word <= cfg_wdata[`CFGL_MODE_CLKS_HI:`CFGL_MODE_CLKS_LO];
            end
            if (wr_mode && cfg_be[0]) begin
                whole_device_reload <= cfg_wdata[`CFGL_MODE_RELOAD];
                core_clock_source <= cfg_wdata[`CFGL_MODE_CLKSRC];
                protocol_load_mode <= cfg_wdata[`CFGL_MODE_PROTO] && st[2];
            end else if (!st[2]) begin
                protocol_load_mode <= 1'b0;
            end
        end
    end

    // clock choice reaches the core only once the fabric runs and is ready
    assign core_clock_source_apply = st[3] && st[7];
    assign route_to_config = protocol_load_mode;

    // each enabled byte lane takes its byte; software is expected to enable all four
    assign wr_word = cfg_data_wr ? cfg_wdata : mem_wdata;
    assign wr_lanes = cfg_data_wr ? cfg_be : mem_be;

    always @* begin
        next_load_data = load_data;
        if (wr_lanes[0]) begin
            next_load_data[7:0] = wr_word[7:0];
        end
        if (wr_lanes[1]) begin
            next_load_data[15:8] = wr_word[15:8];
        end
        if (wr_lanes[2]) begin
            next_load_data[23:16] = wr_word[23:16];
        end
        if (wr_lanes[3]) begin
            next_load_data[31:24] = wr_word[31:24];
        end
    end

    always @(posedge mclk) begin
        if (sys_rst) begin
            load_data <= `CFGL_DATA_RESET;
        end else if (data_wr) begin
            load_data <= next_load_data;
        end
    end

    // low six bits only; zero stands for the full count
    assign pulse_count = (clocks_per_word[`CFGL_MODE_CLKS_USED_HI - `CFGL_MODE_CLKS_LO:0] == 6'h00)
                         ? `CFGL_ZERO_COUNT_CLKS
                         : {1'b0, clocks_per_word[`CFGL_MODE_CLKS_USED_HI - `CFGL_MODE_CLKS_LO:0]};

    cfgl_pulser u_pulser (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .start(data_wr),
        .count(pulse_count),
        .pulse_clk(load_clk),
        .busy(load_busy)
    );

    // unmapped offsets read zero
    always @* begin
        next_rdata = 32'h00000000;
        case (cfg_addr)
            `CFGL_OFS_ID_STATUS: next_rdata = {status_word, BOARD_TYPE_ID};
            `CFGL_OFS_MODE: next_rdata = mode_word;
            `CFGL_OFS_DATA: next_rdata = load_data;
            default: next_rdata = 32'h00000000;
        endcase
    end

    always @(posedge mclk) begin
        if (sys_rst) begin
            cfg_rdata <= 32'h00000000;
        end else if (cfg_rd) begin
            cfg_rdata <= next_rdata;
        end
    end
endmodule // cfgl_regs

// >>> logic/cfgl_sync.v
// three-stage synchroniser for one level arriving from outside the clock domain
// output changes once stages two and three agree
`timescale 1ns/10ps
module cfgl_sync (
    mclk,
    sys_rst,
    din,
    dout
);
    input wire mclk;
    input wire sys_rst;
    input wire din;
    output reg dout;
    reg s1;
    reg s2;
    reg s3;
    always @(posedge mclk) begin
        if (sys_rst) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            dout <= 1'b0;
        end else begin
            s1 <= din;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                dout <= s3;
            end
        end
    end
endmodule // cfgl_sync

// >>> sim/cfgl_ctl_model.sv
// controller-side model: counts load clock pulses of each word
// assumes load_clk idles low between words
`timescale 1ns/10ps
module cfgl_ctl_model (
    input wire mclk,
    input wire load_clk,
    input wire clear,
    output int pulses
);
    logic prev = 1'b0;
    always @(posedge mclk) begin
        prev <= load_clk;
        if (clear)
            pulses <= 0;
        else if (load_clk && !prev)
            pulses <= pulses + 1;
    end
endmodule // cfgl_ctl_model

// >>> sim/cfgl_properties.sv
// timing checks on the loader register block
// sees top-level ports only; bound below
`timescale 1ns/10ps
module cfgl_chk (
    input wire mclk,
    input wire sys_rst,
    input wire cfg_wr,
    input wire cfg_rd,
    input wire [11:0] cfg_addr,
    input wire [31:0] cfg_wdata,
    input wire [31:0] cfg_rdata,
    input wire load_enabled,
    input wire [31:0] load_data,
    input wire load_clk,
    input wire load_busy,
    input wire protocol_load_mode,
    input wire route_to_config
);
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    sequence s_dwr;
        cfg_wr && cfg_addr == 12'h228 && !load_busy;
    endsequence
    sequence s_pulse;
        load_clk ##1 !load_clk;
    endsequence
    property p_data; s_dwr |=> load_data == $past(cfg_wdata); endproperty
    property p_burst; s_dwr |=> load_busy ##1 s_pulse; endproperty
    property p_pulse; load_clk |-> load_busy ##0 s_pulse; endproperty
    property p_route; route_to_config == protocol_load_mode; endproperty
    property p_refuse; !load_enabled [*6] |=> !protocol_load_mode; endproperty
    property p_enter;
        $rose(protocol_load_mode) |-> $past(cfg_wr) && $past(cfg_addr) == 12'h220;
    endproperty
    property p_resv;
        cfg_rd && cfg_addr == 12'h220 |=> cfg_rdata[31:16] == 16'h0 && cfg_rdata[7:3] == 5'h0;
    endproperty
    property p_hold; !cfg_rd |=> $stable(cfg_rdata); endproperty
    a_data: assert property (p_data) else $error("data word not driven");
    a_burst: assert property (p_burst) else $error("burst start late");
    a_pulse: assert property (p_pulse) else $error("bad pulse shape");
    a_route: assert property (p_route) else $error("routing differs");
    a_refuse: assert property (p_refuse) else $error("mode without enable");
    a_enter: assert property (p_enter) else $error("mode set w/o write");
    a_resv: assert property (p_resv) else $error("reserved bits set");
    a_hold: assert property (p_hold) else $error("read data moved");
endmodule // cfgl_chk
bind cfgl_regs cfgl_chk i_cfgl_chk (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd),
    .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata),
    .load_enabled(load_enabled),
    .load_data(load_data),
    .load_clk(load_clk),
    .load_busy(load_busy),
    .protocol_load_mode(protocol_load_mode),
    .route_to_config(route_to_config)
);

// >>> sim/tb_top.sv
// self-checking bench for the loader register block
// drives config strobes and status levels; model counts pulses
`timescale 1ns/10ps
module tb_top;
    logic mclk = 0, sys_rst = 1, cfg_wr = 0, cfg_rd = 0, mem_wr = 0, hit = 0, clr = 0;
    logic [11:0] cfg_addr = 0;
    logic [31:0] cfg_wdata = 0, mem_wdata = 0, cfg_rdata, load_data;
    logic [3:0] be = 4'hF;
    logic [7:0] st = 0;
    logic load_clk, load_busy, plm, wdr, ccs, cca, rtc;
    int pulses, fails = 0, cmp_count = 0, cyc = 0;
    cfgl_regs #(.BOARD_TYPE_ID(16'h5A3C)) i_cfgl_regs (.mclk(mclk), .sys_rst(sys_rst),
        .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
        .cfg_be(be), .cfg_rdata(cfg_rdata), .mem_wr(mem_wr), .mem_bar_hit(hit),
        .mem_wdata(mem_wdata), .mem_be(4'hF), .fabric_core_ready(st[7]),
        .fabric_clock_active(st[6]), .load_done(st[5]), .half_rate_select(st[4]),
        .fabric_running(st[3]), .load_enabled(st[2]), .load_error(st[1]),
        .load_ready(st[0]), .load_data(load_data), .load_clk(load_clk),
        .load_busy(load_busy), .protocol_load_mode(plm), .whole_device_reload(wdr),
        .core_clock_source(ccs), .core_clock_source_apply(cca), .route_to_config(rtc));
    cfgl_ctl_model i_cfgl_ctl_model (.mclk(mclk), .load_clk(load_clk), .clear(clr),
        .pulses(pulses));
    initial forever #20 mclk = ~mclk;
    task close_out;
        $display("checks %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            close_out;
        end
    end
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            fails++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        cfg_wr <= 1;
        cfg_addr <= a;
        cfg_wdata <= d;
        @(posedge mclk);
        cfg_wr <= 0;
    endtask
    task rc(input string n, input logic [11:0] a, input logic [31:0] e);
        @(posedge mclk);
        cfg_rd <= 1;
        cfg_addr <= a;
        @(posedge mclk);
        cfg_rd <= 0;
        @(posedge mclk);
        #1 chk(n, e, cfg_rdata);
    endtask
    task dw(input logic m, input logic [31:0] d, input logic [31:0] ed, input int n);
        @(posedge mclk);
        clr <= 1;
        @(posedge mclk);
        clr <= 0;
        mem_wr <= m;
        hit <= m;
        mem_wdata <= d;
        cfg_wr <= !m;
        cfg_addr <= 12'h228;
        cfg_wdata <= d;
        @(posedge mclk);
        mem_wr <= 0;
        hit <= 0;
        cfg_wr <= 0;
        repeat (3) @(posedge mclk);
        while (load_busy) @(posedge mclk);
        #1 chk("load_data", ed, load_data);
        chk("pulses", n, pulses);
        rc("data rd", 12'h228, ed);
    endtask
    initial begin
        repeat (3) @(posedge mclk);
        sys_rst <= 0;
        rc("mode rst", 12'h220, 32'h0);
        rc("data rst", 12'h228, 32'h0);
        rc("unmapped", 12'h224, 32'h0);
        st <= 8'hA5;
        repeat (6) @(posedge mclk);
        rc("status a", 12'h21C, 32'h02945A3C);
        chk("apply off", 32'h0, cca);
        st <= 8'h5A;
        repeat (6) @(posedge mclk);
        rc("status b", 12'h21C, 32'h01685A3C);
        st <= 8'h88;
        repeat (6) @(posedge mclk);
        #1 chk("apply", 32'h1, cca);
        wr(12'h220, 32'hFFFFFF0F);
        rc("mode", 12'h220, 32'h0000FF06);
        chk("mode pins", 32'h6, {wdr, ccs, plm});
        be <= 4'h1;
        wr(12'h220, 32'h0000AB06);
        be <= 4'hF;
        rc("mode lane", 12'h220, 32'h0000FF06);
        st <= 8'h8C;
        repeat (250) @(posedge mclk);
        wr(12'h220, 32'h00004301);
        #1 chk("route", 32'h1, rtc);
        repeat (250) @(posedge mclk);
        dw(0, 32'hDEADBEEF, 32'hDEADBEEF, 3);
        dw(1, 32'h12345678, 32'h12345678, 3);
        wr(12'h220, 32'h00000001);
        dw(0, 32'hA5A50F0F, 32'hA5A50F0F, 64);
        st <= 8'h88;
        repeat (8) @(posedge mclk);
        #1 chk("mode off", 32'h0, plm);
        dw(1, 32'h0BADF00D, 32'hA5A50F0F, 0);
        close_out;
    end
endmodule // tb_top
